// [rlb_pkg.sv]
/*
 package for the register loop branch unit: opcode codes, field positions,
 timing counts and the execution state type.
 assumes a 50 MHz core clock and a single synchronous reset.
*/
package rlb_pkg;
    // upper six opcode bits of each form
    localparam logic [5:0] OP_INC_REL = 6'h36;
    localparam logic [5:0] OP_INC_ABS = 6'h37;
    localparam logic [5:0] OP_DEC_REL = 6'h3e;
    localparam logic [5:0] OP_DEC_ABS = 6'h3f;
    localparam logic [5:0] OP_TST_REL = 6'h16;
    // field positions
    localparam int OPC_HI = 7;
    localparam int OPC_LO = 2;
    localparam int REG_HI = 1;
    localparam int IND_BIT = 7;
    // byte lengths of the two forms
    localparam logic [14:0] LEN_REL = 15'h0002;
    localparam logic [14:0] LEN_ABS = 15'h0003;
    // timing: three machine cycles of three clock periods each
    localparam int MC_COUNT = 3;
    localparam int PERIODS_PER_MC = 3;
    localparam int EXEC_PERIODS = MC_COUNT * PERIODS_PER_MC;
    localparam logic [3:0] EXEC_LAST = 4'(EXEC_PERIODS - 1);
    // execution states, gray along idle, run, done
    typedef enum logic [1:0] {
        RLB_IDLE = 2'b00,
        RLB_RUN = 2'b01,
        RLB_DONE = 2'b11
    } rlb_state_t;
    // operation classes
    typedef enum logic [1:0] {
        RLB_OP_INC = 2'b00,
        RLB_OP_DEC = 2'b01,
        RLB_OP_TST = 2'b10,
        RLB_OP_NONE = 2'b11
    } rlb_op_t;
endpackage

// [rlb_if.sv]
/*
 interface carrying the decode result from the decoder to the sequencer.
 assumes both ends sit in the core clock domain.
*/
`timescale 1ns/1ns
interface rlb_dec_if;
    import rlb_pkg::*;
    logic hit; // opcode belongs to this group
    rlb_op_t op; // operation class
    logic is_abs; // three-byte form
    logic [1:0] rsel; // selected register
    modport dec (output hit, output op, output is_abs, output rsel);
    modport seq (input hit, input op, input is_abs, input rsel);
endinterface

// [rlb_decoder.sv]
/*
 opcode decoder for the register loop branch group.
 assumes the opcode byte is stable while start is presented.
*/
`timescale 1ns/1ns
module rlb_decoder import rlb_pkg::*; (
    input wire logic [7:0] opcode,
    rlb_dec_if.dec dec
);
    // classify the upper six opcode bits
    always_comb begin
        dec.hit = 1'b1;
        dec.is_abs = 1'b0;
        dec.rsel = opcode[REG_HI:0];
        case (opcode[OPC_HI:OPC_LO])
            OP_INC_REL: dec.op = RLB_OP_INC;
            OP_INC_ABS: begin
                dec.op = RLB_OP_INC;
                dec.is_abs = 1'b1;
            end
            OP_DEC_REL: dec.op = RLB_OP_DEC;
            OP_DEC_ABS: begin
                dec.op = RLB_OP_DEC;
                dec.is_abs = 1'b1;
            end
            OP_TST_REL: dec.op = RLB_OP_TST;
            default: begin
                dec.op = RLB_OP_NONE;
                dec.hit = 1'b0;
            end
        endcase
    end
endmodule

// [rlb_unit.sv]
/*
 register loop branch unit: executes increment, decrement and test
 branches on a selected general register.
 assumes the fetch path presents the opcode, the address of its first byte
 and the already resolved effective address (direct or indirect) with a
 start pulse, and that the register file returns the selected register
 combinationally.
*/
`timescale 1ns/1ns
module rlb_unit import rlb_pkg::*; (
    core_clk,
    srst,
    start,
    opcode,
    ind_flag,
    instr_addr,
    eff_addr,
    reg_rdata,
    busy,
    reg_rsel,
    reg_we,
    reg_wsel,
    reg_wdata,
    iar_we,
    iar_wdata,
    taken,
    ind_req,
    done,
    illegal
);
    input wire logic core_clk; // 50 MHz clock
    input wire logic srst; // synchronous reset, high
    input wire logic start; // one-cycle instruction start
    input wire logic [7:0] opcode; // first instruction byte
    input wire logic ind_flag; // indirect bit of the second byte
    input wire logic [14:0] instr_addr; // address of first byte
    input wire logic [14:0] eff_addr; // resolved branch target
    input wire logic [7:0] reg_rdata; // selected register contents
    output logic busy; // instruction in progress
    output logic [1:0] reg_rsel; // register read select
    output logic reg_we; // register write strobe
    output logic [1:0] reg_wsel; // register write select
    output logic [7:0] reg_wdata; // register write value
    output logic iar_we; // address register load strobe
    output logic [14:0] iar_wdata; // next instruction address
    output logic taken; // branch taken, valid with done
    output logic ind_req; // indirect reference requested
    output logic done; // one-cycle completion
    output logic illegal; // start with foreign opcode

    rlb_dec_if dif ();

    // opcode classification
    rlb_decoder u_dec (
        .opcode(opcode),
        .dec(dif)
    );

    // wrapping update of the register value
    function automatic logic [7:0] upd_val(input rlb_op_t op,
                                           input logic [7:0] v);
        case (op)
            RLB_OP_INC: upd_val = v + 8'h01;
            RLB_OP_DEC: upd_val = v - 8'h01;
            default: upd_val = v;
        endcase
    endfunction

    rlb_state_t state_q, state_d; // sequencer state
    logic [3:0] cnt_q, cnt_d; // clock periods elapsed
    rlb_op_t op_q, op_d; // latched operation
    logic [1:0] rsel_q, rsel_d; // latched register
    logic [7:0] new_q, new_d; // updated register value
    logic take_q, take_d; // branch decision
    logic [14:0] nxt_q, nxt_d; // next instruction address
    logic ind_q, ind_d; // indirect latched
    logic done_q, done_d; // completion pulse
    logic we_q, we_d; // register write pulse
    logic iwe_q, iwe_d; // address load pulse
    logic ill_q, ill_d; // illegal start pulse
    logic [7:0] upd; // combinational update result
    logic [14:0] fall; // fall-through address

    assign upd = upd_val(dif.op, reg_rdata);
    assign fall = instr_addr + (dif.is_abs ? LEN_ABS : LEN_REL);

    // next-state logic of the sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        op_d = op_q;
        rsel_d = rsel_q;
        new_d = new_q;
        take_d = take_q;
        nxt_d = nxt_q;
        ind_d = ind_q;
        done_d = 1'b0;
        we_d = 1'b0;
        iwe_d = 1'b0;
        ill_d = 1'b0;
        case (state_q)
            RLB_IDLE: begin
                if (start && dif.hit) begin
                    // capture operands and decide at once
                    op_d = dif.op;
                    rsel_d = dif.rsel;
                    new_d = upd;
                    take_d = (upd != 8'h00);
                    // target or fall-through
                    nxt_d = (upd != 8'h00) ? eff_addr : fall;
                    ind_d = ind_flag;
                    cnt_d = 4'h1;
                    state_d = RLB_RUN;
                end else if (start) begin
                    ill_d = 1'b1; // not our opcode
                end
            end
            RLB_RUN: begin
                // hold for the full instruction time
                cnt_d = cnt_q + 4'h1;
                // done lands in the ninth period counted from the start cycle
                if (cnt_q == EXEC_LAST) begin
                    state_d = RLB_DONE;
                    done_d = 1'b1;
                    // write back only for loop forms
                    we_d = (op_q != RLB_OP_TST);
                    iwe_d = 1'b1;
                end
            end
            RLB_DONE: begin
                state_d = RLB_IDLE;
                cnt_d = 4'h0;
                ind_d = 1'b0;
            end
            default: begin
                state_d = RLB_IDLE;
                cnt_d = 4'h0;
            end
        endcase
    end

    // register stage of the sequencer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= RLB_IDLE;
            cnt_q <= 4'h0;
            op_q <= RLB_OP_NONE;
            rsel_q <= 2'h0;
            new_q <= 8'h00;
            take_q <= 1'b0;
            nxt_q <= 15'h0000;
            ind_q <= 1'b0;
            done_q <= 1'b0;
            we_q <= 1'b0;
            iwe_q <= 1'b0;
            ill_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            rsel_q <= rsel_d;
            new_q <= new_d;
            take_q <= take_d;
            nxt_q <= nxt_d;
            ind_q <= ind_d;
            done_q <= done_d;
            we_q <= we_d;
            iwe_q <= iwe_d;
            ill_q <= ill_d;
        end
    end

    // outputs; no condition code or other register port exists
    assign busy = (state_q != RLB_IDLE);
    assign reg_rsel = dif.rsel;
    assign reg_we = we_q;
    assign reg_wsel = rsel_q;
    assign reg_wdata = new_q;
    assign iar_we = iwe_q;
    assign iar_wdata = nxt_q;
    assign taken = take_q;
    assign ind_req = ind_q;
    assign done = done_q;
    assign illegal = ill_q;
endmodule

// [rlb_unit_monitor.sv]
/* checker on rlb_unit ports: timing, write-back, branch outcome.
 assumes one core clock and bind onto rlb_unit. */
`timescale 1ns/1ns
module rlb_monitor import rlb_pkg::*; (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] reg_rdata,
    input wire logic busy,
    input wire logic reg_we,
    input wire logic [7:0] reg_wdata,
    input wire logic iar_we,
    input wire logic taken,
    input wire logic done,
    input wire logic illegal
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (srst);
    wire logic [5:0] u = opcode[7:2]; // upper opcode bits
    wire logic go = start && !busy; // start that may be taken
    wire logic g = u inside {OP_INC_REL, OP_INC_ABS, OP_DEC_REL,
        OP_DEC_ABS, OP_TST_REL}; // opcode of this group
    wire logic inc = go && (u == OP_INC_REL || u == OP_INC_ABS);
    wire logic dec = go && (u == OP_DEC_REL || u == OP_DEC_ABS);
    wire logic tst = go && u == OP_TST_REL; // test-only form
    chk_done_nine: assert property (go && g |-> ##1 !done[*8] ##1 (done && iar_we))
        else $error("done not nine cycles after start");
    chk_busy_span: assert property (go && g |-> ##1 busy[*8])
        else $error("busy dropped during execution");
    chk_inc_wrap: assert property (inc |-> ##9 reg_we &&
        reg_wdata == 8'($past(reg_rdata, 9) + 8'h01)) else $error("bad increment");
    chk_dec_wrap: assert property (dec |-> ##9 reg_we &&
        reg_wdata == 8'($past(reg_rdata, 9) - 8'h01)) else $error("bad decrement");
    chk_step_taken: assert property (inc || dec |-> ##9 taken == (reg_wdata != 8'h00))
        else $error("branch decision wrong");
    chk_test_keep: assert property (tst |-> ##9 !reg_we &&
        taken == ($past(reg_rdata, 9) != 8'h00)) else $error("test form wrong");
    chk_foreign_op: assert property (go && !g |-> ##[1:2] illegal)
        else $error("foreign opcode not flagged");
    chk_we_alone: assert property (reg_we |-> done)
        else $error("register write outside completion");
    cover property (done && taken);
    cover property (done && !taken);
    cover property (illegal);
endmodule
bind rlb_unit rlb_monitor u_mon (.*);

// [test_register_loop_branch_unit.sv]
/* self-checking bench for rlb_unit with random and corner operands.
 assumes the bench plays fetch path and register file itself. */
`timescale 1ns/1ns
module test_register_loop_branch_unit import rlb_pkg::*;;
    logic core_clk = 0, srst = 1, start = 0, ind_flag = 0; // inputs
    logic [7:0] opcode = 0, reg_rdata = 0, v; // opcode, register value
    logic [14:0] instr_addr = 0, eff_addr = 0; // addresses
    logic busy, reg_we, iar_we, taken, ind_req, done, illegal; // flags
    logic [1:0] reg_rsel, reg_wsel; // register selects
    logic [7:0] reg_wdata; // write-back value
    logic [14:0] iar_wdata; // next address
    logic [5:0] ops [5] = '{OP_INC_REL, OP_INC_ABS, OP_DEC_REL,
        OP_DEC_ABS, OP_TST_REL}; // every form
    logic [7:0] corner [3] = '{8'hff, 8'h01, 8'h00}; // wrap edges
    int n_mismatch = 0, samples_checked = 0, cyc = 0; // counters
    rlb_unit u_dut (.core_clk(core_clk), .srst(srst), .start(start),
        .opcode(opcode), .ind_flag(ind_flag), .instr_addr(instr_addr),
        .eff_addr(eff_addr), .reg_rdata(reg_rdata), .busy(busy),
        .reg_rsel(reg_rsel), .reg_we(reg_we), .reg_wsel(reg_wsel),
        .reg_wdata(reg_wdata), .iar_we(iar_we), .iar_wdata(iar_wdata),
        .taken(taken), .ind_req(ind_req), .done(done), .illegal(illegal));
    // free-running 50 MHz clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // register value after the operation
    function automatic logic [7:0] f_new(logic [5:0] u, logic [7:0] x);
        if (u == OP_INC_REL || u == OP_INC_ABS) return x + 8'h01;
        if (u == OP_TST_REL) return x;
        return x - 8'h01;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one instruction, optionally with an ignored start while busy
    task automatic run_op(input logic [5:0] u, input logic [7:0] x, input bit pok);
        logic [7:0] r;
        logic [14:0] fall;
        int n;
        opcode = {u, 2'($urandom)};
        reg_rdata = x;
        ind_flag = 1'($urandom);
        instr_addr = 15'($urandom);
        eff_addr = 15'($urandom);
        start = 1'b1;
        r = f_new(u, x);
        fall = instr_addr + ((u == OP_INC_ABS || u == OP_DEC_ABS) ? 15'h3 : 15'h2);
        n = 0;
        @(negedge core_clk);
        start = 1'b0;
        while (done !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
            start = pok && n == 3; // refused while busy
        end
        chk(n, 32'(EXEC_LAST));
        chk(taken, r != 8'h00);
        chk(iar_we, 1'b1);
        chk(iar_wdata, r != 8'h00 ? eff_addr : fall);
        chk(reg_we, u != OP_TST_REL);
        if (u != OP_TST_REL) chk({reg_wsel, reg_wdata}, {opcode[1:0], r});
        chk(ind_req, ind_flag);
        @(negedge core_clk);
        chk(done | iar_we | reg_we, 1'b0);
        for (n = 0; n < 4 && busy !== 1'b0; n++) @(negedge core_clk);
    endtask
    // main sequence
    initial begin
        void'($urandom(15));
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        srst = 1'b0;
        for (int i = 0; i < 40; i++) begin
            v = i < 15 ? corner[i % 3] : 8'($urandom);
            run_op(ops[i % 5], v, i % 2);
            $display("test %0d ended", i);
        end
        opcode = 8'h00; // foreign opcode
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        v[0] = illegal;
        @(negedge core_clk);
        chk(v[0] | illegal, 1'b1);
        chk(busy, 1'b0);
        $display("test foreign ended");
        wrap_up();
    end
endmodule
